// ### rtl/baud_pkg.sv
package baud_pkg;
  // bus geometry
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  // register byte addresses
  localparam logic [11:0] OFS_MODE_TWO_CH0 = 12'h205;
  localparam logic [11:0] OFS_BAUD_CONTROL = 12'h20b;
  localparam logic [11:0] OFS_BAUD_FRACTION = 12'h20c;
  localparam logic [11:0] OFS_MODE_TWO_CH1 = 12'h20d;
  // baud control field positions
  localparam int POS_FRAC_EN = 6;
  localparam int POS_PRESCALE_HI = 5;
  localparam int POS_PRESCALE_LO = 4;
  localparam int POS_DIVISOR_LSB = 0;
  localparam int BAUD_CTL_BITS = 7;
  // baud fraction field positions
  localparam int POS_FRACTION_LSB = 0;
  localparam int POS_PHASE_LSB = 4;
  // second mode register field positions
  localparam int POS_IDLE_RUN = 7;
  localparam int POS_DUPLEX = 6;
  // reset values
  localparam logic [6:0] RST_BAUD_CTL = 7'h00;
  localparam logic [3:0] RST_FRACTION = 4'h0;
  localparam logic [1:0] RST_MODE_TWO = 2'h0;
  // prescaler tap select codes
  localparam logic [1:0] TAP_SEL_A = 2'h0;
  localparam logic [1:0] TAP_SEL_B = 2'h1;
  localparam logic [1:0] TAP_SEL_C = 2'h2;
  localparam logic [1:0] TAP_SEL_D = 2'h3;
  // divisor and fraction codes with special meaning
  localparam logic [3:0] DIV_CODE_SIXTEEN = 4'h0;
  localparam logic [3:0] DIV_CODE_ONE = 4'h1;
  localparam logic [3:0] FRACTION_OFF = 4'h0;
endpackage

// ### rtl/frac_divider.sv
`timescale 1ns/100ps
module frac_divider import baud_pkg::*; #(
  parameter int DIV_BITS = 4
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic tick_in,
  input wire logic [DIV_BITS-1:0] divisor_code,
  input wire logic [DIV_BITS-1:0] fraction_k,
  input wire logic fraction_on,
  output logic tick_out,
  output logic [DIV_BITS-1:0] phase
);
  localparam int CNT_BITS = DIV_BITS + 1;
  localparam logic [CNT_BITS-1:0] FULL_SPAN = CNT_BITS'(1 << DIV_BITS);

  // the fraction step is tied to the 4-bit field layout
  generate
    if (DIV_BITS != 4) begin : g_bad_width
      $error("frac_divider supports DIV_BITS = 4 only");
    end
  endgenerate

  typedef struct packed {
    logic [CNT_BITS-1:0] cnt;
    logic [DIV_BITS-1:0] acc;
    logic stretch;
    logic tick;
  } div_state_t;

  div_state_t div_reg, div_next;
  logic [CNT_BITS-1:0] n_value;
  logic [CNT_BITS-1:0] top;
  logic [CNT_BITS-1:0] step;
  logic [CNT_BITS-1:0] sum;

  // period arithmetic
  always_comb begin
    // RULE2: zero code means sixteen
    n_value = (divisor_code == '0) ? FULL_SPAN : {1'b0, divisor_code};
    top = n_value - CNT_BITS'(1) + CNT_BITS'(div_reg.stretch);
    step = FULL_SPAN - {1'b0, fraction_k};
    sum = {1'b0, div_reg.acc} + step;
  end

  // counter with bresenham stretch; >= keeps a shrunk divisor from running away
  always_comb begin
    div_next = div_reg;
    div_next.tick = 1'b0;
    if (tick_in) begin
      if (div_reg.cnt >= top) begin
        div_next.cnt = '0;
        div_next.tick = 1'b1;
        // RULE14: stretch 16-K of 16 periods
        if (fraction_on) begin
          div_next.acc = sum[DIV_BITS-1:0];
          div_next.stretch = sum[DIV_BITS];
        end else begin
          // RULE3: plain divide by n
          div_next.acc = '0;
          div_next.stretch = 1'b0;
        end
      end else begin
        div_next.cnt = div_reg.cnt + CNT_BITS'(1);
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_next;
    end
  end

  assign tick_out = div_reg.tick;
  assign phase = div_reg.acc;
endmodule

// ### rtl/serial_baud_ctrl.sv
`timescale 1ns/100ps
// Function
// RULE1: a 2-bit select picks prescaler tap a, b, c or d for codes 00, 01, 10 and 11.
// RULE2: the 4-bit divisor field gives N from 1 to 15, and code 0000 means N of 16.
// RULE3: the fraction enable adds (16-K)/16 to the divide when set, and plain N is used when clear.
// RULE4: the 4-bit fraction field holds K, where 1 to 15 give N + (16-K)/16 and 0 turns the fraction off.
// RULE5: the fraction only acts for N from 2 to 15 and only in a UART mode, never in I/O mode.
// RULE6: software uses N of 1 without fraction only in UART modes, not in synchronous I/O mode.
// RULE7: software writes a nonzero K before it sets the fraction enable.
// RULE8: writes to the upper four bits of the fraction register are ignored and their read value is free.
// RULE9: software never does read-modify-write on the channel 0 data buffer.
// RULE10: software never does read-modify-write on the channel 1 data buffer.
// RULE11: bit 7 of each second mode register keeps the channel running in light sleep when 1, stops it when 0.
// RULE12: bit 6 of each second mode register selects full duplex when 1 and half duplex when 0.
// RULE13: all implemented bits of the baud control and fraction registers reset to zero, bit 7 is written 0.
// RULE14: the fraction is made by lengthening 16-K of every 16 output periods by one input tick.
// RULE15: in synchronous output mode with full duplex, transmit and receive use opposite clock edges.
module serial_baud_ctrl import baud_pkg::*; (
  input wire logic mclk,
  input wire logic sys_rst,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  // prescaler ticks, one cycle each, from the mclk prescaler
  input wire logic prescale_tap_a,
  input wire logic prescale_tap_b,
  input wire logic prescale_tap_c,
  input wire logic prescale_tap_d,
  // channel 1 operating mode from the channel's own mode logic
  input wire logic uart_mode_ch1,
  input wire logic sclk_output_mode_ch1,
  input wire logic edge_select_ch1,
  // power state from the clock controller
  input wire logic light_sleep_state,
  // outputs to the channels
  output logic baud_tick,
  output logic baud_clock,
  output logic run_enable_ch0,
  output logic run_enable_ch1,
  output logic duplex_select_ch0,
  output logic duplex_select_ch1,
  output logic tx_on_falling_ch1,
  output logic rx_on_falling_ch1
);

  typedef struct packed {
    logic [BAUD_CTL_BITS-1:0] baud_ctl;
    logic [3:0] fraction;
    logic idle_run_select_ch0;
    logic duplex_select_ch0;
    logic idle_run_select_ch1;
    logic duplex_select_ch1;
    logic [DATA_W-1:0] rdata;
    logic tap_tick;
    logic baud_tick;
    logic baud_clock;
    logic run_ch0;
    logic run_ch1;
    logic tx_fall;
    logic rx_fall;
  } ctrl_state_t;

  ctrl_state_t ctrl_reg, ctrl_next;

  // decoded fields of the baud control and fraction registers, and signals derived from them
  logic fraction_divide_enable;
  logic prescale_select_high;
  logic prescale_select_low;
  logic [3:0] integer_divisor_field;
  logic [3:0] fraction_term_field;
  logic [1:0] tap_select;
  logic tap_now;
  logic fraction_allowed;
  logic fraction_active;
  logic div_tick;
  logic [3:0] div_phase;

  // field split of the stored control bits
  always_comb begin
    fraction_divide_enable = ctrl_reg.baud_ctl[POS_FRAC_EN];
    prescale_select_high = ctrl_reg.baud_ctl[POS_PRESCALE_HI];
    prescale_select_low = ctrl_reg.baud_ctl[POS_PRESCALE_LO];
    integer_divisor_field = ctrl_reg.baud_ctl[POS_DIVISOR_LSB +: 4];
    fraction_term_field = ctrl_reg.fraction;
    tap_select = {prescale_select_high, prescale_select_low};
  end

  // input tap multiplexer
  always_comb begin
    // RULE1: tap select decode
    unique case (tap_select)
      TAP_SEL_A: tap_now = prescale_tap_a;
      TAP_SEL_B: tap_now = prescale_tap_b;
      TAP_SEL_C: tap_now = prescale_tap_c;
      TAP_SEL_D: tap_now = prescale_tap_d;
    endcase
  end

  // fraction qualification; N of 1 or 16 would make the stretch dominate the period
  always_comb begin
    // RULE5: valid for n 2..15 in uart
    fraction_allowed = (integer_divisor_field != DIV_CODE_SIXTEEN)
      && (integer_divisor_field != DIV_CODE_ONE)
      && uart_mode_ch1;
    // RULE4: zero k keeps fraction off
    fraction_active = fraction_divide_enable
      && (fraction_term_field != FRACTION_OFF)
      && fraction_allowed;
  end

  // divide engine, fed from the registered tap tick
  frac_divider #(
    .DIV_BITS(4)
  ) u_divider (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .tick_in(ctrl_reg.tap_tick),
    .divisor_code(integer_divisor_field),
    .fraction_k(fraction_term_field),
    .fraction_on(fraction_active),
    .tick_out(div_tick),
    .phase(div_phase)
  );

  // next-state logic for registers, readback and channel controls
  always_comb begin
    ctrl_next = ctrl_reg;
    ctrl_next.tap_tick = tap_now;
    ctrl_next.baud_tick = div_tick;
    ctrl_next.rdata = '0;

    // register writes; unmapped addresses are ignored
    if (reg_wr) begin
      unique case (reg_addr)
        OFS_MODE_TWO_CH0: begin
          // RULE11: idle run bit channel 0
          ctrl_next.idle_run_select_ch0 = reg_wdata[POS_IDLE_RUN];
          // RULE12: duplex bit channel 0
          ctrl_next.duplex_select_ch0 = reg_wdata[POS_DUPLEX];
        end
        OFS_BAUD_CONTROL: begin
          // RULE13: bit 7 not stored
          ctrl_next.baud_ctl = reg_wdata[BAUD_CTL_BITS-1:0];
        end
        OFS_BAUD_FRACTION: begin
          // RULE8: upper nibble discarded
          ctrl_next.fraction = reg_wdata[POS_FRACTION_LSB +: 4];
        end
        OFS_MODE_TWO_CH1: begin
          // RULE11: idle run bit channel 1
          ctrl_next.idle_run_select_ch1 = reg_wdata[POS_IDLE_RUN];
          // RULE12: duplex bit channel 1
          ctrl_next.duplex_select_ch1 = reg_wdata[POS_DUPLEX];
        end
        default: begin
        end
      endcase
    end

    // register reads, data valid the cycle after the strobe
    if (reg_rd) begin
      unique case (reg_addr)
        OFS_MODE_TWO_CH0: begin
          ctrl_next.rdata[POS_IDLE_RUN] = ctrl_reg.idle_run_select_ch0;
          ctrl_next.rdata[POS_DUPLEX] = ctrl_reg.duplex_select_ch0;
        end
        OFS_BAUD_CONTROL: begin
          ctrl_next.rdata = {1'b0, ctrl_reg.baud_ctl};
        end
        OFS_BAUD_FRACTION: begin
          // free upper bits show the live fraction phase, handy for debug
          ctrl_next.rdata = {div_phase, ctrl_reg.fraction};
        end
        OFS_MODE_TWO_CH1: begin
          ctrl_next.rdata[POS_IDLE_RUN] = ctrl_reg.idle_run_select_ch1;
          ctrl_next.rdata[POS_DUPLEX] = ctrl_reg.duplex_select_ch1;
        end
        default: begin
          ctrl_next.rdata = '0;
        end
      endcase
    end

    // half-rate clock for the synchronous shift clock
    if (div_tick) begin
      ctrl_next.baud_clock = ~ctrl_reg.baud_clock;
    end

    // RULE11: stop in light sleep unless run
    ctrl_next.run_ch0 = ~light_sleep_state | ctrl_reg.idle_run_select_ch0;
    ctrl_next.run_ch1 = ~light_sleep_state | ctrl_reg.idle_run_select_ch1;

    // receive follows the edge select; transmit follows it too in half duplex
    ctrl_next.rx_fall = edge_select_ch1;
    ctrl_next.tx_fall = edge_select_ch1;
    // RULE15: opposite edge in full duplex
    if (sclk_output_mode_ch1 && ~uart_mode_ch1 && ctrl_reg.duplex_select_ch1) begin
      ctrl_next.tx_fall = ~edge_select_ch1;
    end
  end

  // single state register
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ctrl_reg <= '0;
      // RULE13: control and fraction cleared
      ctrl_reg.baud_ctl <= RST_BAUD_CTL;
      ctrl_reg.fraction <= RST_FRACTION;
      {ctrl_reg.idle_run_select_ch0, ctrl_reg.duplex_select_ch0} <= RST_MODE_TWO;
      {ctrl_reg.idle_run_select_ch1, ctrl_reg.duplex_select_ch1} <= RST_MODE_TWO;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  // outputs straight from the state register
  assign reg_rdata = ctrl_reg.rdata;
  assign baud_tick = ctrl_reg.baud_tick;
  assign baud_clock = ctrl_reg.baud_clock;
  assign run_enable_ch0 = ctrl_reg.run_ch0;
  assign run_enable_ch1 = ctrl_reg.run_ch1;
  assign duplex_select_ch0 = ctrl_reg.duplex_select_ch0;
  assign duplex_select_ch1 = ctrl_reg.duplex_select_ch1;
  assign tx_on_falling_ch1 = ctrl_reg.tx_fall;
  assign rx_on_falling_ch1 = ctrl_reg.rx_fall;

endmodule

// ### dv/serial_baud_ctrl_chk.sv
`timescale 1ns/100ps
module serial_baud_ctrl_chk import baud_pkg::*; (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic prescale_tap_a,
  input wire logic prescale_tap_b,
  input wire logic prescale_tap_c,
  input wire logic prescale_tap_d,
  input wire logic uart_mode_ch1,
  input wire logic sclk_output_mode_ch1,
  input wire logic edge_select_ch1,
  input wire logic light_sleep_state,
  input wire logic baud_tick,
  input wire logic baud_clock,
  input wire logic run_enable_ch0,
  input wire logic run_enable_ch1,
  input wire logic duplex_select_ch1,
  input wire logic tx_on_falling_ch1,
  input wire logic rx_on_falling_ch1
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // read data only in the cycle after a read strobe
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00) else $error("rdata not idle");
  // bit 7 of the baud control is never stored
  a_ctl_bit7: assert property ($past(reg_rd) && $past(reg_addr) == OFS_BAUD_CONTROL |-> !reg_rdata[7])
    else $error("ctl bit7 set");
  // unused channel 1 mode bits read zero
  a_mode_low: assert property ($past(reg_rd) && $past(reg_addr) == OFS_MODE_TWO_CH1 |-> reg_rdata[5:0] == 6'h00)
    else $error("mode low bits");
  // a tick only ends a period that a tap tick closed
  // tap is registered, counted, then the tick registered again: three edges back
  a_tick_tap: assert property (baud_tick |-> $past(prescale_tap_a | prescale_tap_b | prescale_tap_c | prescale_tap_d, 3))
    else $error("tick without tap");
  // shift clock flips with every divided tick
  a_clock_toggle: assert property (baud_tick |-> baud_clock != $past(baud_clock))
    else $error("baud clock not toggled");
  a_rx_edge: assert property (rx_on_falling_ch1 == $past(edge_select_ch1)) else $error("rx edge");
  a_tx_opposite: assert property ((sclk_output_mode_ch1 && !uart_mode_ch1 && duplex_select_ch1)[*3] |->
    tx_on_falling_ch1 != rx_on_falling_ch1) else $error("tx edge not opposite");
  // three cycles so the cleared run flops of reset have passed
  a_run_awake: assert property ((!light_sleep_state)[*3] |-> run_enable_ch0 && run_enable_ch1)
    else $error("run enable low");
  a_duplex_write: assert property ($past(reg_wr) && $past(reg_addr) == OFS_MODE_TWO_CH1 |=>
    duplex_select_ch1 == $past(reg_wdata[6], 2)) else $error("duplex not stored");
endmodule
bind serial_baud_ctrl serial_baud_ctrl_chk chk (.mclk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .prescale_tap_a, .prescale_tap_b, .prescale_tap_c, .prescale_tap_d, .uart_mode_ch1, .sclk_output_mode_ch1,
  .edge_select_ch1, .light_sleep_state, .baud_tick, .baud_clock, .run_enable_ch0, .run_enable_ch1, .duplex_select_ch1,
  .tx_on_falling_ch1, .rx_on_falling_ch1);

// ### dv/serial_baud_ctrl_tb.sv
`timescale 1ns/100ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin n_mismatch++; $display("CHECK FAILED t=%0t %h %h", $time, a, e); end end
module serial_baud_ctrl_tb import baud_pkg::*; ;
  logic mclk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, uart_mode_ch1 = 1'b1;
  logic sclk_output_mode_ch1 = 1'b0, edge_select_ch1 = 1'b0, light_sleep_state = 1'b0;
  logic prescale_tap_a = 1'b0, prescale_tap_b = 1'b0, prescale_tap_c = 1'b0, prescale_tap_d = 1'b0;
  logic [ADDR_W-1:0] reg_addr = 12'h000;
  logic [DATA_W-1:0] reg_wdata = 8'h00, reg_rdata;
  logic baud_tick, run_enable_ch0, run_enable_ch1, duplex_select_ch0, duplex_select_ch1, tx_on_falling_ch1;
  logic rx_on_falling_ch1, baud_clock;
  logic [3:0] ph = 4'h0;
  int n_mismatch = 0, compares = 0;
  serial_baud_ctrl DUT (.mclk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .prescale_tap_a,
    .prescale_tap_b, .prescale_tap_c, .prescale_tap_d, .uart_mode_ch1, .sclk_output_mode_ch1, .edge_select_ch1,
    .light_sleep_state, .baud_tick, .baud_clock, .run_enable_ch0, .run_enable_ch1, .duplex_select_ch0,
    .duplex_select_ch1, .tx_on_falling_ch1, .rx_on_falling_ch1);
  initial begin
    forever #5 mclk = ~mclk;
  end
  // 12-cycle pattern so taps a..d tick every 1..4 cycles
  always @(posedge mclk) begin
    ph <= (ph == 4'hb) ? 4'h0 : ph + 4'h1;
    prescale_tap_a <= 1'b1;
    prescale_tap_b <= (ph % 2 == 0);
    prescale_tap_c <= (ph % 3 == 0);
    prescale_tap_d <= (ph % 4 == 0);
  end
  // bench never touches the data buffers, so no read-modify-write
  // idle cycle after the strobe so back-to-back writes never drive reg_wr twice in one step
  task wr(input logic [11:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    @(posedge mclk);
  endtask
  // read data stand one cycle only, so look mid-cycle
  task rd(input logic [11:0] a, input logic [7:0] m, input logic [7:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    `CHK(reg_rdata & m, e)
    @(posedge mclk);
  endtask
  // skip two ticks so old settings flush, then time 16 periods
  task meas(input int e);
    int c;
    int n;
    c = 0;
    n = 0;
    while (n < 18 && c < 5000) begin
      @(posedge mclk);
      if (n >= 2) c++;
      if (baud_tick === 1'b1) n++;
    end
    `CHK(c, e)
  endtask
  task t_regs();
    rd(OFS_BAUD_CONTROL, 8'hff, 8'h00);
    rd(OFS_BAUD_FRACTION, 8'h0f, 8'h00);
    rd(OFS_MODE_TWO_CH0, 8'hff, 8'h00);
    wr(OFS_BAUD_CONTROL, 8'h3f);
    rd(OFS_BAUD_CONTROL, 8'hff, 8'h3f);
    wr(OFS_MODE_TWO_CH0, 8'hff);
    wr(12'h20e, 8'hff);
    rd(12'h20e, 8'hff, 8'h00);
    rd(OFS_MODE_TWO_CH0, 8'hff, 8'hc0);
    `CHK(duplex_select_ch0, 1'b1)
    $display("regs done");
  endtask
  task t_div();
    for (int s = 0; s < 4; s++) begin
      wr(OFS_BAUD_CONTROL, {2'b00, 2'(s), 4'h3});
      meas(48 * (s + 1));
    end
    wr(OFS_BAUD_CONTROL, 8'h00);
    meas(256);
    wr(OFS_BAUD_CONTROL, 8'h01);
    meas(16);
    wr(OFS_BAUD_FRACTION, 8'hf3);
    rd(OFS_BAUD_FRACTION, 8'h0f, 8'h03);
    wr(OFS_BAUD_CONTROL, 8'h45);
    meas(93);
    wr(OFS_BAUD_CONTROL, 8'h41);
    meas(16);
    wr(OFS_BAUD_CONTROL, 8'h40);
    meas(256);
    uart_mode_ch1 <= 1'b0;
    wr(OFS_BAUD_CONTROL, 8'h45);
    meas(80);
    uart_mode_ch1 <= 1'b1;
    wr(OFS_BAUD_FRACTION, 8'h00);
    meas(80);
    $display("div done");
  endtask
  task t_ctrl();
    wr(OFS_MODE_TWO_CH1, 8'hc0);
    sclk_output_mode_ch1 <= 1'b1;
    uart_mode_ch1 <= 1'b0;
    edge_select_ch1 <= 1'b1;
    light_sleep_state <= 1'b1;
    repeat (3) @(posedge mclk);
    `CHK({tx_on_falling_ch1, rx_on_falling_ch1}, 2'b01)
    `CHK({run_enable_ch0, run_enable_ch1}, 2'b11)
    uart_mode_ch1 <= 1'b1;
    wr(OFS_MODE_TWO_CH0, 8'h00);
    wr(OFS_MODE_TWO_CH1, 8'h80);
    repeat (3) @(posedge mclk);
    `CHK({tx_on_falling_ch1, rx_on_falling_ch1}, 2'b11)
    `CHK({run_enable_ch0, run_enable_ch1, duplex_select_ch1}, 3'b010)
    light_sleep_state <= 1'b0;
    repeat (3) @(posedge mclk);
    `CHK({run_enable_ch0, run_enable_ch1}, 2'b11)
    $display("ctrl done");
  endtask
  task close_out();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // a hung tick wait must not stall the run
  initial begin
    #100000;
    n_mismatch++;
    close_out();
  end
  initial begin
    repeat (4) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    t_regs();
    t_div();
    t_ctrl();
    close_out();
  end
endmodule
